// ==== include/line_alarm_pkg.sv ====
// Package for the line-unit alarm interrupt block: offsets, fields, types.
// Assumes a 32-bit classic Wishbone bus with byte addresses.
package line_alarm_pkg;
	localparam logic [11:0] ADDR_IRQ_EN = 12'hf04;
	localparam logic [11:0] ADDR_STATUS = 12'hf05;
	localparam logic [11:0] ADDR_EVENT = 12'hf08;
	localparam logic [11:0] ADDR_CTRL = 12'hf0c;
	localparam int BIT_PATTERN = 0;
	localparam int BIT_SIGLOSS = 1;
	localparam int BIT_FIFO = 5;
	localparam int BIT_DRVMON = 6;
	localparam int NUM_SRC = 4;
	localparam logic [7:0] EN_MASK = 8'h63;
	localparam logic [7:0] STATUS_RESET = 8'h00;
	localparam logic [7:0] EN_RESET = 8'h00;
	localparam logic [7:0] CNT_LIMIT = 8'h80;
	localparam logic [7:0] FIFO_NEAR = 8'h03;
	localparam logic [31:0] DEAD_DATA = 32'h00000000;
	typedef struct packed {
		logic tx_line_positive;
		logic tx_line_negative;
		logic signal_loss_defect;
		logic pattern_detect;
	} line_in_t;
	typedef struct packed {
		logic [7:0] wr_ptr;
		logic [7:0] rd_ptr;
	} fifo_ptr_t;
	typedef enum logic [1:0] {
		BUS_IDLE = 2'b01,
		BUS_ACK = 2'b10
	} bus_state_t;
endpackage

// ==== rtl/line_unit_alarm_interrupts.sv ====
// Alarm status, change detection and interrupt enables of one T1 line channel.
// Assumes line pins are asynchronous to I_SYS_CLK and sampled at least per bit.
// Function
// RULE1: With bit 1 enabled, both declaring and clearing signal loss raise an interrupt.
// RULE2: With bit 0 enabled, both gaining and losing test-pattern lock raise an interrupt.
// RULE3: Software sets line unit and framer to single rail mode before using these registers.
// RULE4: The driver-monitor alarm is declared after 128 bit periods without a bipolar pulse.
// RULE5: Any bipolar pulse on the line output clears the driver-monitor alarm at once.
// RULE6: Status bit 6 reads 1 while the driver-monitor alarm is declared.
// RULE7: With bit 6 enabled, every change of the driver-monitor status raises an interrupt.
// RULE8: Status bit 5 reads 1 while the jitter FIFO pointers are within three bits.
// RULE9: With bit 5 enabled, every change of the FIFO limit status raises an interrupt.
// RULE10: Unused status bits 7 and 4 read as zero.
// RULE11: The interrupt output is the OR of enabled sticky events, held until cleared.
`default_nettype none
module line_unit_alarm_interrupts (
	input wire logic I_SYS_CLK,
	input wire logic I_RST_N,
	input wire logic I_CYC,
	input wire logic I_STB,
	input wire logic I_WE,
	input wire logic [11:0] I_ADR,
	input wire logic [3:0] I_SEL,
	input wire logic [31:0] I_DAT,
	output logic [31:0] O_DAT,
	output logic O_ACK,
	input wire logic I_BIT_TICK,
	input wire line_alarm_pkg::line_in_t I_LINE,
	input wire line_alarm_pkg::fifo_ptr_t I_FIFO,
	output logic O_IRQ
);

////////////////////////////////////////////////////////////////////////////////
// Pin synchronisers; first stage feeds only the second
line_alarm_pkg::line_in_t line_s1;
line_alarm_pkg::line_in_t line_s2;
logic tick_s1;
logic tick_s2;
logic tick_d;
always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
	if (!I_RST_N) begin
		line_s1 <= '0;
		line_s2 <= '0;
		tick_s1 <= 1'b0;
		tick_s2 <= 1'b0;
		tick_d <= 1'b0;
	end else begin
		line_s1 <= I_LINE;
		line_s2 <= line_s1;
		tick_s1 <= I_BIT_TICK;
		tick_s2 <= tick_s1;
		tick_d <= tick_s2;
	end
end

logic bit_edge;
assign bit_edge = tick_s2 && !tick_d;

////////////////////////////////////////////////////////////////////////////////
// Driver monitor: count quiet bit periods
logic [7:0] quiet_cnt;
logic drv_alarm;
logic pulse_seen;
assign pulse_seen = line_s2.tx_line_positive || line_s2.tx_line_negative;
always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
	if (!I_RST_N) begin
		quiet_cnt <= 8'h00;
		drv_alarm <= 1'b0;
	end else if (pulse_seen) begin
		quiet_cnt <= 8'h00; // [RULE5]
		drv_alarm <= 1'b0; // [RULE5]
	end else if (bit_edge && !drv_alarm) begin
		if (quiet_cnt == line_alarm_pkg::CNT_LIMIT - 8'h01) begin
			drv_alarm <= 1'b1; // [RULE4]
		end else begin
			quiet_cnt <= quiet_cnt + 8'h01; // [RULE4]
		end
	end
end

////////////////////////////////////////////////////////////////////////////////
// FIFO limit; pointers come from the same clock, so no synchroniser
logic [7:0] ptr_diff;
logic fifo_near;
always_comb begin
	ptr_diff = I_FIFO.wr_ptr - I_FIFO.rd_ptr;
	fifo_near = (ptr_diff <= line_alarm_pkg::FIFO_NEAR) ||
		((8'h00 - ptr_diff) <= line_alarm_pkg::FIFO_NEAR); // [RULE8]
end

logic fifo_flag;
always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
	if (!I_RST_N) begin
		fifo_flag <= 1'b0;
	end else begin
		fifo_flag <= fifo_near;
	end
end

////////////////////////////////////////////////////////////////////////////////
// Status assembly; bits 7, 4 and loop code stay zero
logic [7:0] status;
always_comb begin
	status = line_alarm_pkg::STATUS_RESET; // [RULE10]
	status[line_alarm_pkg::BIT_DRVMON] = drv_alarm; // [RULE6]
	status[line_alarm_pkg::BIT_FIFO] = fifo_flag; // [RULE8]
	status[line_alarm_pkg::BIT_SIGLOSS] = line_s2.signal_loss_defect;
	status[line_alarm_pkg::BIT_PATTERN] = line_s2.pattern_detect;
end

////////////////////////////////////////////////////////////////////////////////
// Wishbone slave, one wait state so reads come from flops
line_alarm_pkg::bus_state_t bus_state;
logic access;
logic ack_phase;
logic wr_en;
logic wr_event;
logic wr_ctrl;
assign access = I_CYC && I_STB && (bus_state == line_alarm_pkg::BUS_IDLE);
// Writes land on the edge where the master sees ack, not on the taking edge
assign ack_phase = I_CYC && I_STB && (bus_state == line_alarm_pkg::BUS_ACK);
assign wr_en = ack_phase && I_WE && I_SEL[0] && (I_ADR == line_alarm_pkg::ADDR_IRQ_EN);
assign wr_event = ack_phase && I_WE && I_SEL[0] && (I_ADR == line_alarm_pkg::ADDR_EVENT);
assign wr_ctrl = ack_phase && I_WE && I_SEL[0] && (I_ADR == line_alarm_pkg::ADDR_CTRL);

always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
	if (!I_RST_N) begin
		bus_state <= line_alarm_pkg::BUS_IDLE;
	end else begin
		case (bus_state)
			line_alarm_pkg::BUS_IDLE: begin
				if (access) begin
					bus_state <= line_alarm_pkg::BUS_ACK;
				end
			end
			line_alarm_pkg::BUS_ACK: begin
				bus_state <= line_alarm_pkg::BUS_IDLE;
			end
			default: begin
				bus_state <= line_alarm_pkg::BUS_IDLE;
			end
		endcase
	end
end
assign O_ACK = (bus_state == line_alarm_pkg::BUS_ACK);

////////////////////////////////////////////////////////////////////////////////
// Enable register and single rail control
logic [7:0] irq_en;
logic single_rail;
always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
	if (!I_RST_N) begin
		irq_en <= line_alarm_pkg::EN_RESET;
		single_rail <= 1'b0;
	end else begin
		if (wr_en) begin
			irq_en <= I_DAT[7:0] & line_alarm_pkg::EN_MASK;
		end
		if (wr_ctrl) begin
			single_rail <= I_DAT[0];
		end
	end
end

////////////////////////////////////////////////////////////////////////////////
// Change detection and sticky events, one per source
localparam int SRC_BIT [line_alarm_pkg::NUM_SRC] = '{
	line_alarm_pkg::BIT_PATTERN, line_alarm_pkg::BIT_SIGLOSS,
	line_alarm_pkg::BIT_FIFO, line_alarm_pkg::BIT_DRVMON};
logic [7:0] status_d;
wire logic [7:0] event_flag;
always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
	if (!I_RST_N) begin
		status_d <= line_alarm_pkg::STATUS_RESET;
	end else begin
		status_d <= status;
	end
end

genvar g;
generate
	for (g = 0; g < 8; g++) begin : g_evt
		if (g == SRC_BIT[0] || g == SRC_BIT[1] || g == SRC_BIT[2] || g == SRC_BIT[3]) begin : g_on
			logic change;
			logic flag;
			// Registers only work in single rail mode, so changes are ignored otherwise
			assign change = single_rail && (status[g] != status_d[g]); // [RULE3]
			always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
				if (!I_RST_N) begin
					flag <= 1'b0;
				end else if (change) begin
					flag <= 1'b1; // [RULE1] [RULE2] [RULE7] [RULE9]
				end else if (wr_event && I_DAT[g]) begin
					flag <= 1'b0;
				end
			end
			assign event_flag[g] = flag;
		end else begin : g_off
			assign event_flag[g] = 1'b0;
		end
	end
endgenerate

////////////////////////////////////////////////////////////////////////////////
// Interrupt output and read data
always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
	if (!I_RST_N) begin
		O_IRQ <= 1'b0;
	end else begin
		O_IRQ <= |(event_flag & irq_en); // [RULE11]
	end
end

always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
	if (!I_RST_N) begin
		O_DAT <= line_alarm_pkg::DEAD_DATA;
	end else if (access && !I_WE) begin
		case (I_ADR)
			line_alarm_pkg::ADDR_IRQ_EN: O_DAT <= {24'h000000, irq_en};
			line_alarm_pkg::ADDR_STATUS: O_DAT <= {24'h000000, single_rail ? status : 8'h00};
			line_alarm_pkg::ADDR_EVENT: O_DAT <= {24'h000000, event_flag};
			line_alarm_pkg::ADDR_CTRL: O_DAT <= {31'h00000000, single_rail};
			default: O_DAT <= line_alarm_pkg::DEAD_DATA;
		endcase
	end else begin
		O_DAT <= line_alarm_pkg::DEAD_DATA;
	end
end

endmodule
`default_nettype wire

// ==== testbench/line_alarm_properties.sv ====
// Checker: bus timing, status bits and interrupt relations.
// Assumes it is bound to the block's top ports.
`default_nettype none
module line_alarm_properties (
	input wire logic I_SYS_CLK,
	input wire logic I_RST_N,
	input wire logic I_CYC,
	input wire logic I_STB,
	input wire logic I_WE,
	input wire logic [11:0] I_ADR,
	input wire logic [3:0] I_SEL,
	input wire logic [31:0] I_DAT,
	input wire logic [31:0] O_DAT,
	input wire logic O_ACK,
	input wire logic I_BIT_TICK,
	input wire line_alarm_pkg::line_in_t I_LINE,
	input wire line_alarm_pkg::fifo_ptr_t I_FIFO,
	input wire logic O_IRQ
);
	default clocking @(posedge I_SYS_CLK); endclocking
	default disable iff (!I_RST_N);
	logic rd_st, pulse, near;
	logic [7:0] gap;
	assign rd_st = O_ACK && !I_WE && I_ADR == line_alarm_pkg::ADDR_STATUS;
	assign pulse = I_LINE.tx_line_positive | I_LINE.tx_line_negative;
	assign gap = I_FIFO.wr_ptr - I_FIFO.rd_ptr;
	assign near = gap <= 8'h03 || gap >= 8'hfd;
	////////////////////////////////////////
	sequence s_req; $rose(I_STB) && I_CYC; endsequence
	sequence s_ans; O_ACK ##1 !O_ACK; endsequence
	// Pin path is synchronised, so allow a few cycles of lag
	sequence s_busy; pulse [*6]; endsequence
	property p_ack; s_req |=> s_ans; endproperty
	property p_drop; O_ACK |=> !O_ACK; endproperty
	property p_idle; !O_ACK |-> O_DAT == 32'h0; endproperty
	property p_upper; O_ACK |-> O_DAT[31:8] == 24'h0; endproperty
	property p_unused; rd_st |-> !O_DAT[7] && !O_DAT[4]; endproperty
	property p_fifo; rd_st && O_DAT[5] |-> $past(near) || $past(near, 2) || $past(near, 3);
	endproperty
	property p_dmo; s_busy ##1 rd_st |-> !O_DAT[6]; endproperty
	property p_mask; O_ACK && I_WE && I_SEL[0] && I_ADR == line_alarm_pkg::ADDR_IRQ_EN
		&& I_DAT[7:0] == 8'h00 |-> ##2 !O_IRQ; endproperty
	a_ack: assert property (p_ack) else $error("ack not one cycle after request");
	a_drop: assert property (p_drop) else $error("ack longer than one cycle");
	a_idle: assert property (p_idle) else $error("read data not zero outside ack");
	a_upper: assert property (p_upper) else $error("upper read data not zero");
	a_unused: assert property (p_unused) else $error("unused status bit set");
	a_fifo: assert property (p_fifo) else $error("fifo flag without near pointers");
	a_dmo: assert property (p_dmo) else $error("monitor alarm despite pulses");
	a_mask: assert property (p_mask) else $error("irq with all enables off");
endmodule
bind line_unit_alarm_interrupts line_alarm_properties u_line_alarm_properties (
	.I_SYS_CLK(I_SYS_CLK), .I_RST_N(I_RST_N), .I_CYC(I_CYC), .I_STB(I_STB), .I_WE(I_WE),
	.I_ADR(I_ADR), .I_SEL(I_SEL), .I_DAT(I_DAT), .O_DAT(O_DAT), .O_ACK(O_ACK),
	.I_BIT_TICK(I_BIT_TICK), .I_LINE(I_LINE), .I_FIFO(I_FIFO), .O_IRQ(O_IRQ));
`default_nettype wire

// ==== testbench/line_unit_alarm_interrupts_tb.sv ====
// Bench: registers, alarm inputs and interrupt output.
// Assumes the package is compiled first; drives every input itself.
`default_nettype none
module line_unit_alarm_interrupts_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 0, rst_n = 0, cyc = 0, stb = 0, we = 0, ack, irq, tick = 0;
	logic [11:0] adr = 0;
	logic [3:0] sel = 0;
	logic [31:0] wd = 0, rd, q;
	line_alarm_pkg::line_in_t ln = '0;
	line_alarm_pkg::fifo_ptr_t ff = '0;
	int error_cnt = 0, checks = 0;
	line_unit_alarm_interrupts u_line_unit_alarm_interrupts (.I_SYS_CLK(clk), .I_RST_N(rst_n),
		.I_CYC(cyc), .I_STB(stb), .I_WE(we), .I_ADR(adr), .I_SEL(sel), .I_DAT(wd), .O_DAT(rd),
		.O_ACK(ack), .I_BIT_TICK(tick), .I_LINE(ln), .I_FIFO(ff), .O_IRQ(irq));
	initial begin
		forever #5 clk = ~clk;
	end
	////////////////////////////////////////
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		checks++;
		if (s !== e) begin
			error_cnt++;
			$display("unexpected at %0t: saw %h, wanted %h", $time, s, e);
		end
	endtask
	task automatic summarize();
		$display("checks %0d errors %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	task automatic bus(input logic w, input logic [11:0] a, input logic [7:0] d);
		int n;
		n = 0;
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		sel <= 4'hf;
		wd <= {24'h0, d};
		do begin
			@(posedge clk);
			n++;
		end while (ack !== 1'b1 && n < 20);
		q = rd;
		chk(ack, 1'b1);
		cyc <= 1'b0;
		stb <= 1'b0;
		repeat (2) @(posedge clk);
	endtask
	task automatic rdc(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
		bus(1'b0, a, 8'h0);
		chk(q & m, e);
	endtask
	// Pulses ride on the high half of each bit tick
	task automatic ticks(input int n, input logic p);
		repeat (n) begin
			tick <= 1'b1;
			ln.tx_line_positive <= p;
			repeat (4) @(posedge clk);
			tick <= 1'b0;
			ln.tx_line_positive <= 1'b0;
			repeat (4) @(posedge clk);
		end
	endtask
	function automatic logic [7:0] st_exp(input logic [7:0] w, input logic [7:0] r);
		logic [7:0] g;
		g = w - r;
		return {2'b00, g <= 8'h03 || g >= 8'hfd, 5'h0};
	endfunction
	////////////////////////////////////////
	initial begin
		logic [7:0] w, r, e, pe;
		void'($urandom(59319));
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		rdc(line_alarm_pkg::ADDR_IRQ_EN, 32'hff, 32'h0);
		rdc(line_alarm_pkg::ADDR_STATUS, 32'hff, 32'h0);
		bus(1'b1, line_alarm_pkg::ADDR_IRQ_EN, 8'hff);
		rdc(line_alarm_pkg::ADDR_IRQ_EN, 32'hffffffff, 32'h63);
		rdc(12'h123, 32'hffffffff, 32'h0);
		bus(1'b1, line_alarm_pkg::ADDR_CTRL, 8'h01);
		for (int b = 0; b < 3; b++) begin
			bus(1'b1, line_alarm_pkg::ADDR_IRQ_EN, b < 2 ? 8'h1 << b : 8'h0);
			bus(1'b1, line_alarm_pkg::ADDR_EVENT, 8'hff);
			chk(irq, 1'b0);
			ln[b % 2] <= ~ln[b % 2];
			repeat (6) @(posedge clk);
			chk(irq, b < 2);
			rdc(line_alarm_pkg::ADDR_EVENT, 32'h3, 32'h1 << (b % 2));
		end
		bus(1'b1, line_alarm_pkg::ADDR_IRQ_EN, 8'h20);
		pe = 8'h20;
		for (int k = 0; k < 12; k++) begin
			bus(1'b1, line_alarm_pkg::ADDR_EVENT, 8'hff);
			w = 8'($urandom);
			r = k < 4 ? w - (k[0] ? 8'h03 : 8'h04) * (k < 2 ? 8'h01 : 8'hff) : 8'($urandom);
			ff <= {w, r};
			e = st_exp(w, r);
			repeat (3) @(posedge clk);
			rdc(line_alarm_pkg::ADDR_STATUS, 32'hb0, {24'h0, e});
			chk(irq, e != pe);
			pe = e;
		end
		bus(1'b1, line_alarm_pkg::ADDR_IRQ_EN, 8'h40);
		ticks(3, 1'b1);
		bus(1'b1, line_alarm_pkg::ADDR_EVENT, 8'hff);
		ticks(127, 1'b0);
		rdc(line_alarm_pkg::ADDR_STATUS, 32'h40, 32'h0);
		chk(irq, 1'b0);
		ticks(1, 1'b0);
		rdc(line_alarm_pkg::ADDR_STATUS, 32'h40, 32'h40);
		chk(irq, 1'b1);
		bus(1'b1, line_alarm_pkg::ADDR_EVENT, 8'hff);
		ticks(1, 1'b1);
		rdc(line_alarm_pkg::ADDR_STATUS, 32'h40, 32'h0);
		chk(irq, 1'b1);
		summarize();
	end
	initial begin
		repeat (20000) @(posedge clk);
		error_cnt++;
		summarize();
	end
endmodule
`default_nettype wire
